/* File: hw/cfnes_consts.svh */
// Offsets, field positions, reset values and codes for the CF/NAND steering
`ifndef CFNES_CONSTS_SVH
`define CFNES_CONSTS_SVH

`define CFNES_ADDR_W 32
`define CFNES_WIN_MSB 31
`define CFNES_WIN_LSB 28
`define CFNES_WIN_NAND 4'h4
`define CFNES_WIN_SLOT0 4'h5
`define CFNES_WIN_SLOT1 4'h6
`define CFNES_BASE_NAND 32'h4000_0000
`define CFNES_LAST_NAND 32'h4FFF_FFFF
`define CFNES_BASE_SLOT0 32'h5000_0000
`define CFNES_BASE_SLOT1 32'h6000_0000

`define CFNES_MODE_MSB 23
`define CFNES_MODE_LSB 21
`define CFNES_ALE_BIT 21
`define CFNES_CLE_BIT 22
`define CFNES_A25_BIT 25

`define CFNES_MODE_ATTR 3'h0
`define CFNES_MODE_COMMON 3'h2
`define CFNES_MODE_IO 3'h4
`define CFNES_MODE_IDE 3'h6
`define CFNES_MODE_ALT_IDE 3'h7

`define CFNES_CS0_BYTE_SEL_RST 1'h1
`define CFNES_CS0_WIDTH16_RST 1'h1
`define CFNES_CS0_CS_CTRL_RST 1'h1

`endif

/* File: hw/cfnes_mode_decode.sv */
// Decodes the CF mode from transfer address bits 23 to 21
`include "cfnes_consts.svh"
module cfnes_mode_decode
  import cfnes_pkg::*;
(
  // Address
  input wire logic [2:0] mode_bits,
  // Decoded mode
  output cfnes_mode_type mode
);

  // Unlisted codes fall back on A23 memory/I-O and A22 choice
  function automatic cfnes_mode_type decode_mode(input logic [2:0] b);
    cfnes_mode_type m;
    m = CFNES_ATTR;
    if (b == `CFNES_MODE_ALT_IDE) begin
      m = CFNES_ALT_IDE;
    end else if (b[2] && b[1]) begin
      m = CFNES_IDE;
    end else if (b[2]) begin
      m = CFNES_IO;
    end else if (b[1]) begin
      m = CFNES_COMMON;
    end
    return m;
  endfunction

  assign mode = decode_mode(mode_bits);

endmodule

/* File: hw/cfnes_pkg.sv */
// Types shared by the CF/NAND steering modules
package cfnes_pkg;

  typedef enum logic [2:0] {
    CFNES_ATTR    = 3'b000,
    CFNES_COMMON  = 3'b010,
    CFNES_IO      = 3'b100,
    CFNES_IDE     = 3'b110,
    CFNES_ALT_IDE = 3'b111
  } cfnes_mode_type;

  // Controller side of one external access
  typedef struct packed {
    logic [31:0] addr;
    logic read_strobe_n;
    logic write_strobe0_n;
    logic write_byte1_select_n;
    logic write_byte3_select_n;
    logic chip_select3_n;
    logic chip_select4_n;
    logic chip_select5_n;
    logic write_access;
  } cfnes_smc_type;

  // Shared and dedicated external pins
  typedef struct packed {
    logic rd_cf_output_enable_n;
    logic wr0_cf_write_enable_n;
    logic bs1_cf_io_read_strobe_n;
    logic bs3_cf_io_write_strobe_n;
    logic a25_cf_read_not_write;
    logic cs4_cf_slot0_select_n;
    logic cs5_cf_slot1_select_n;
    logic chip_select3_n;
  } cfnes_pins_type;

  // NAND control pins
  typedef struct packed {
    logic nand_output_enable_n;
    logic nand_write_enable_n;
    logic nand_ale;
    logic nand_cle;
  } cfnes_nand_type;

  // Chip select 0 mode after reset
  typedef struct packed {
    logic byte_select;
    logic width16;
    logic cs_controlled;
  } cfnes_cs0_type;

endpackage

/* File: hw/cfnes_steering.sv */
// CF and NAND strobe and chip-select steering on shared bus pins
`include "cfnes_consts.svh"
module cfnes_steering
  import cfnes_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Chip select assignment enables
  input wire logic slot0_cf_assign,
  input wire logic slot1_cf_assign,
  input wire logic nand_assign,
  input wire logic sdram_assign,
  // Controller mode settings
  input wire logic nand_width16,
  input wire logic cs0_mode_load,
  input wire cfnes_cs0_type cs0_mode_in,
  // Static memory controller side
  input wire cfnes_smc_type static_memory_ctrl,
  output logic smc_wait_n,
  // External pins
  output cfnes_pins_type pins,
  output cfnes_nand_type nand_pins,
  output logic [`CFNES_ADDR_W-1:0] ext_addr,
  input wire logic external_wait_n,
  // Status
  output cfnes_mode_type cf_mode,
  output logic cf_access,
  output logic nand_access,
  output logic nand_bus_width16,
  output logic sdram_on_cs1,
  output cfnes_cs0_type cs0_mode
);

  // Window decode from the upper address nibble
  function automatic logic in_window(input logic [31:0] a,
                                     input logic [3:0] win);
    return a[`CFNES_WIN_MSB:`CFNES_WIN_LSB] == win;
  endfunction

  // Mode and direction held through a CF access
  cfnes_mode_type mode_now;
  cfnes_mode_type mode_r;
  cfnes_mode_type mode_nxt;
  cfnes_mode_type mode_use;
  logic active_r;
  logic rnw_r;
  logic rnw_nxt;

  // Next pin values
  cfnes_pins_type pins_nxt;
  cfnes_nand_type nand_nxt;

  // Registered status
  cfnes_cs0_type cs0_r;
  logic nand_w16_r;
  logic cf_access_r;
  logic nand_access_r;
  logic sdram_r;
  logic [`CFNES_ADDR_W-1:0] addr_r;

  cfnes_mode_decode u_decode (
    .mode_bits(static_memory_ctrl.addr[`CFNES_MODE_MSB:`CFNES_MODE_LSB]),
    .mode(mode_now)
  );

  // slot windows gated by assignment enable
  wire slot0_hit = slot0_cf_assign && !static_memory_ctrl.chip_select4_n &&
                   in_window(static_memory_ctrl.addr, `CFNES_WIN_SLOT0);
  wire slot1_hit = slot1_cf_assign && !static_memory_ctrl.chip_select5_n &&
                   in_window(static_memory_ctrl.addr, `CFNES_WIN_SLOT1);
  wire cf_hit = slot0_hit || slot1_hit;

  // NAND window gated by assignment enable
  wire nand_hit = nand_assign && !static_memory_ctrl.chip_select3_n &&
                  in_window(static_memory_ctrl.addr, `CFNES_WIN_NAND);

  // A mid-access mode change would move a live strobe
  // onto another pin, so the first cycle's decode is kept
  // mode and direction captured on the first access cycle
  assign mode_use = active_r ? mode_r : mode_now;
  assign mode_nxt = cf_hit ? mode_use : mode_r;
  // Buffer direction must not flip while data is on the bus
  // direction held stable through the transfer
  assign rnw_nxt = active_r ? rnw_r : !static_memory_ctrl.write_access;

  // Decoder folds unlisted codes into the listed modes
  wire mem_mode = (mode_use == CFNES_ATTR) ||
                  (mode_use == CFNES_COMMON);
  wire ide_mode = (mode_use == CFNES_IDE) ||
                  (mode_use == CFNES_ALT_IDE);

  // Card strobes before the shared-pin choice
  // memory modes route to OE/WE; I/O holds them high
  wire cf_output_enable_n = mem_mode ? static_memory_ctrl.read_strobe_n :
                (ide_mode ? 1'b0 : 1'b1);
  wire cf_write_enable_n = mem_mode ? static_memory_ctrl.write_strobe0_n : 1'b1;
  // I/O and IDE modes route to I/O read/write
  wire cf_io_read_strobe_n = mem_mode ? 1'b1 : static_memory_ctrl.read_strobe_n;
  wire cf_io_write_strobe_n = mem_mode ? 1'b1 : static_memory_ctrl.write_strobe0_n;

  assign pins_nxt.rd_cf_output_enable_n = cf_hit ? cf_output_enable_n : static_memory_ctrl.read_strobe_n;
  assign pins_nxt.wr0_cf_write_enable_n = cf_hit ? cf_write_enable_n : static_memory_ctrl.write_strobe0_n;
  assign pins_nxt.bs1_cf_io_read_strobe_n = cf_hit ? cf_io_read_strobe_n :
                                static_memory_ctrl.write_byte1_select_n;
  assign pins_nxt.bs3_cf_io_write_strobe_n = cf_hit ? cf_io_write_strobe_n :
                                static_memory_ctrl.write_byte3_select_n;
  assign pins_nxt.a25_cf_read_not_write = cf_hit ? rnw_nxt :
                              static_memory_ctrl.addr[`CFNES_A25_BIT];
  // Same register stage as the chip select, so buffer
  // enables open and close with it
  // dedicated pins; slot select is the chip select gated by the slot window when assigned
  assign pins_nxt.cs4_cf_slot0_select_n = slot0_cf_assign ? !slot0_hit :
                                static_memory_ctrl.chip_select4_n;
  assign pins_nxt.cs5_cf_slot1_select_n = slot1_cf_assign ? !slot1_hit :
                                static_memory_ctrl.chip_select5_n;
  assign pins_nxt.chip_select3_n = static_memory_ctrl.chip_select3_n;

  // Outside the window the strobes serve other devices
  // NAND strobes only inside the chip-select-3 window
  assign nand_nxt.nand_output_enable_n =
    nand_hit ? static_memory_ctrl.read_strobe_n : 1'b1;
  assign nand_nxt.nand_write_enable_n =
    nand_hit ? static_memory_ctrl.write_strobe0_n : 1'b1;
  // Latch enables ungated: ignored while NAND strobes idle
  // latch enables straight from the address
  assign nand_nxt.nand_ale = static_memory_ctrl.addr[`CFNES_ALE_BIT];
  assign nand_nxt.nand_cle = static_memory_ctrl.addr[`CFNES_CLE_BIT];

  // Not registered, so a card wait stretches this access
  // card wait passed to the controller
  assign smc_wait_n = external_wait_n;

  always_ff @(posedge clock) begin
    if (reset) begin
      active_r <= 1'b0;
      mode_r <= CFNES_ATTR;
      rnw_r <= 1'b1;
    end else begin
      active_r <= cf_hit;
      mode_r <= mode_nxt;
      rnw_r <= rnw_nxt;
    end
  end

  // Pins registered together so relative timing is kept
  always_ff @(posedge clock) begin
    if (reset) begin
      // Strobes and selects idle high, latch enables low
      pins <= '1;
      nand_pins.nand_output_enable_n <= 1'h1;
      nand_pins.nand_write_enable_n <= 1'h1;
      nand_pins.nand_ale <= 1'h0;
      nand_pins.nand_cle <= 1'h0;
      addr_r <= '0;
    end else begin
      pins <= pins_nxt;
      nand_pins <= nand_nxt;
      addr_r <= static_memory_ctrl.addr;
    end
  end

  // Status follows the pins with the same one-cycle lag
  // NAND data width follows chip select 3 setting
  always_ff @(posedge clock) begin
    if (reset) begin
      nand_w16_r <= 1'b0;
      cf_access_r <= 1'b0;
      nand_access_r <= 1'b0;
      sdram_r <= 1'b0;
    end else begin
      nand_w16_r <= nand_width16;
      cf_access_r <= cf_hit;
      nand_access_r <= nand_hit;
      sdram_r <= sdram_assign;
    end
  end

  // boot defaults for chip select 0
  always_ff @(posedge clock) begin
    if (reset) begin
      cs0_r.byte_select <= `CFNES_CS0_BYTE_SEL_RST;
      cs0_r.width16 <= `CFNES_CS0_WIDTH16_RST;
      cs0_r.cs_controlled <= `CFNES_CS0_CS_CTRL_RST;
    end else if (cs0_mode_load) begin
      cs0_r <= cs0_mode_in;
    end
  end

  // Outputs straight from flip-flops
  assign ext_addr = addr_r;
  assign cf_mode = mode_r;
  assign cf_access = cf_access_r;
  assign nand_access = nand_access_r;
  assign nand_bus_width16 = nand_w16_r;
  assign sdram_on_cs1 = sdram_r;
  assign cs0_mode = cs0_r;

endmodule

/* File: tb/cfnes_card_model.sv */
// Card slot model that stretches a selected access when slow
module cfnes_card_model
  import cfnes_pkg::*;
(
  // Clock and pins
  input wire logic clock,
  input wire cfnes_pins_type pins,
  // Slow card
  input wire logic slow,
  // Card wait
  output logic external_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_r = 2'h0;
  always_ff @(posedge clock)
    hold_r <= pins.cs4_cf_slot0_select_n ? 2'h2 : hold_r - {1'b0, hold_r != 2'h0};
  assign external_wait_n = ~(slow & ~pins.cs4_cf_slot0_select_n & hold_r != 2'h0);
endmodule

/* File: tb/cfnes_monitor.sv */
// Port checker for the CF/NAND steering block
module cfnes_monitor
  import cfnes_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Inputs
  input wire logic nand_assign,
  input wire cfnes_smc_type static_memory_ctrl,
  input wire logic external_wait_n,
  // Outputs
  input wire cfnes_pins_type pins,
  input wire cfnes_nand_type nand_pins,
  input wire logic smc_wait_n,
  input wire cfnes_mode_type cf_mode,
  input wire logic cf_access
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire nh = nand_assign & ~static_memory_ctrl.chip_select3_n & static_memory_ctrl.addr[31:28] == 4'h4;
  sequence cf_run;
    cf_access [*2];
  endsequence
  a_nand_oe: assert property (
    nh |=> nand_pins.nand_output_enable_n == $past(static_memory_ctrl.read_strobe_n))
    else $error("nand oe not routed");
  a_nand_drop: assert property (
    !nh |=> nand_pins.nand_output_enable_n && nand_pins.nand_write_enable_n)
    else $error("nand strobes left active");
  a_latch_bits: assert property (
    nh |=> {nand_pins.nand_ale, nand_pins.nand_cle} ==
      {$past(static_memory_ctrl.addr[21]), $past(static_memory_ctrl.addr[22])})
    else $error("latch enables wrong");
  a_slot0_pin: assert property (
    1'b1 |=> pins.cs4_cf_slot0_select_n == $past(static_memory_ctrl.chip_select4_n))
    else $error("slot select timing wrong");
  a_plain_path: assert property (
    !cf_access && !$past(reset) |->
      pins.rd_cf_output_enable_n == $past(static_memory_ctrl.read_strobe_n) &&
      pins.bs1_cf_io_read_strobe_n == $past(static_memory_ctrl.write_byte1_select_n))
    else $error("plain bus path wrong");
  a_io_quiet: assert property (
    cf_access && cf_mode == CFNES_IO |-> pins.rd_cf_output_enable_n && pins.wr0_cf_write_enable_n)
    else $error("io mode oe or we active");
  a_ide_levels: assert property (
    cf_access && cf_mode[2:1] == 2'h3 |-> !pins.rd_cf_output_enable_n && pins.wr0_cf_write_enable_n)
    else $error("ide oe or we level wrong");
  a_mem_quiet: assert property (
    cf_access && !cf_mode[2] |-> pins.bs1_cf_io_read_strobe_n && pins.bs3_cf_io_write_strobe_n)
    else $error("memory mode io strobes active");
  a_io_route: assert property (
    cf_access && cf_mode[2] |->
      pins.bs1_cf_io_read_strobe_n == $past(static_memory_ctrl.read_strobe_n) &&
      pins.bs3_cf_io_write_strobe_n == $past(static_memory_ctrl.write_strobe0_n))
    else $error("io strobes not routed");
  a_mem_route: assert property (
    cf_access && !cf_mode[2] |->
      pins.rd_cf_output_enable_n == $past(static_memory_ctrl.read_strobe_n) &&
      pins.wr0_cf_write_enable_n == $past(static_memory_ctrl.write_strobe0_n))
    else $error("memory strobes not routed");
  a_mode_frozen: assert property (
    cf_run |-> $stable(cf_mode) && $stable(pins.a25_cf_read_not_write))
    else $error("mode or direction moved");
  a_wait_copy: assert property (
    smc_wait_n == external_wait_n) else $error("wait not passed");
endmodule

bind cfnes_steering cfnes_monitor cfnes_monitor_i (.clock, .reset,
  .nand_assign, .static_memory_ctrl, .external_wait_n, .pins, .nand_pins, .smc_wait_n,
  .cf_mode, .cf_access);

/* File: tb/cfnes_steering_bench.sv */
// Self-checking bench for the CF/NAND steering block
module cfnes_steering_bench
  import cfnes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] a;
    logic [2:0] c;
    logic r, w;
    logic [6:0] e;
  } cfnes_row_type;
  logic clock = 1'b0, reset = 1'b1, s0 = 1'b1, s1 = 1'b1, ns = 1'b1;
  logic sdr = 1'b0, w16 = 1'b0, ld = 1'b0, slow = 1'b0, ew_n, wn, nw, sc;
  cfnes_cs0_type c0 = 3'h2, cm;
  cfnes_smc_type s = {32'h0000_0000, 4'hd, 3'h7, 1'b0};
  cfnes_pins_type p;
  cfnes_nand_type np;
  cfnes_mode_type md;
  logic [31:0] ea;
  logic ca, na;
  int err_total = 0, check_count = 0;
  cfnes_row_type t [8] = '{
    '{32'h5000_0000, 3'h5, 1'b0, 1'b1, 7'h3f},
    '{32'h5040_0000, 3'h5, 1'b1, 1'b0, 7'h5b},
    '{32'h6080_0000, 3'h6, 1'b0, 1'b1, 7'h6f},
    '{32'h5080_0000, 3'h5, 1'b1, 1'b0, 7'h73},
    '{32'h50c0_0000, 3'h5, 1'b0, 1'b1, 7'h2f},
    '{32'h50e0_0000, 3'h5, 1'b1, 1'b0, 7'h33},
    '{32'h4000_0000, 3'h3, 1'b0, 1'b1, 7'h29},
    '{32'h5200_0000, 3'h7, 1'b1, 1'b0, 7'h4f}};
  always #2.5 clock = ~clock;
  cfnes_steering cfnes_steering_i (.clock(clock), .reset(reset),
    .slot0_cf_assign(s0), .slot1_cf_assign(s1), .nand_assign(ns),
    .sdram_assign(sdr), .nand_width16(w16), .cs0_mode_load(ld),
    .cs0_mode_in(c0), .static_memory_ctrl(s), .smc_wait_n(wn), .pins(p), .nand_pins(np),
    .ext_addr(ea), .external_wait_n(ew_n), .cf_mode(md), .cf_access(ca),
    .nand_access(na), .nand_bus_width16(nw), .sdram_on_cs1(sc),
    .cs0_mode(cm));
  // card alone on its select pin
  cfnes_card_model cfnes_card_model_i (.clock(clock), .pins(p),
    .slow(slow), .external_wait_n(ew_n));
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic drv(input logic [31:0] a, input logic [2:0] c,
    input logic r, w);
    @(negedge clock);
    s = {a, r, w, 2'h1, c, ~w};
  endtask
  task automatic look;
    @(posedge clock);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) look;
    chk({cm, p, np}, 15'h7ffc);
    $display("test reset done");
    @(negedge clock);
    reset = 1'b0;
    foreach (t[i]) begin
      drv(t[i].a, t[i].c, t[i].r, t[i].w);
      look;
      chk({p[7:3], np[3:2]}, t[i].e);
      chk(ea, t[i].a);
      chk({p[0], p[2], p[1]}, t[i].c);
      drv(32'h0, 3'h7, 1'b1, 1'b1);
    end
    $display("test rows done");
    s0 = 1'b0;
    drv(32'h5080_0000, 3'h5, 1'b0, 1'b1);
    look;
    chk({p[7:5], p[2], ca}, 5'h08);
    drv(32'h0, 3'h7, 1'b1, 1'b1);
    s0 = 1'b1;
    slow = 1'b1;
    drv(32'h5080_0000, 3'h5, 1'b0, 1'b1);
    look;
    chk(wn, 1'b0);
    drv(32'h5000_0000, 3'h5, 1'b0, 1'b1);
    look;
    chk({p[7], p[5], p[3], md}, {3'h5, CFNES_IO});
    drv(32'h0, 3'h7, 1'b1, 1'b1);
    slow = 1'b0;
    $display("test freeze done");
    // A21 and A22 raised for latch cycles
    drv(32'h4060_0000, 3'h3, 1'b1, 1'b0);
    look;
    chk(np, 4'hb);
    chk(na, 1'b1);
    drv(32'h5060_0000, 3'h3, 1'b1, 1'b0);
    look;
    chk(np[3:2], 2'h3);
    chk(na, 1'b0);
    drv(32'h0, 3'h7, 1'b1, 1'b1);
    w16 = 1'b1;
    sdr = 1'b1;
    ld = 1'b1;
    @(negedge clock);
    ld = 1'b0;
    chk({nw, sc, cm}, 5'h1a);
    $display("test nand done");
    reset = 1'b1;
    @(negedge clock);
    chk({nw, sc, cm}, 5'h07);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    chk({p, np}, 12'hd7c);
    $display("test second reset done");
    results;
  end
  initial begin
    repeat (400) @(posedge clock);
    err_total++;
    results;
  end
endmodule
